// ==== rtl/vpic_pkg.sv ====
// Purpose: shared constants of the vectored priority interrupt controller
// Assumes: 26 controller inputs, four arbitration groups of six
// Notes:   source index = group * 6 + slot; rtc alarm 24, adc 25
package vpic_pkg;
    localparam int SRC_NUM    = 26;
    localparam int GROUP_NUM  = 4;
    localparam int UNIT_IN    = 6;
    localparam int PROG_IN    = 4;
    localparam int RTC_IDX    = 24;
    localparam int ADC_IDX    = 25;

    // vector table layout
    localparam logic [31:0] VEC_FIRST      = 32'h0000_0020;
    localparam logic [31:0] VEC_GROUP_STEP = 32'h0000_0020;
    localparam logic [31:0] VEC_SLOT_STEP  = 32'h0000_0004;
    localparam logic [31:0] VEC_RTC        = 32'h0000_00A0;
    localparam logic [31:0] VEC_ADC        = 32'h0000_00C0;

    // exception fetch addresses and branch encoding
    localparam logic [31:0] IRQ_FETCH   = 32'h0000_0018;
    localparam logic [31:0] FIQ_FETCH   = 32'h0000_001C;
    localparam logic [31:0] BRANCH_BASE = 32'hEA00_0000;
    localparam logic [31:0] PC_AHEAD    = 32'h0000_0008;

    // values after reset
    localparam logic [25:0] PENDING_RESET = 26'h000_0000;
    localparam logic [1:0]  ROT_RESET     = 2'h0;
    localparam logic [31:0] INSN_RESET    = 32'h0000_0000;
endpackage

// ==== rtl/vpic_rank_if.sv ====
// Purpose: carrier between the controller and one priority unit
// Assumes: six inputs, four programmable and two fixed
// Notes:   order holds four 2-bit input numbers, rank 0 first
`timescale 1ns/1ps
`default_nettype none
interface vpic_rank_if;
    logic [5:0] req;
    logic [7:0] order;
    logic       rr_en;
    logic       advance;
    logic       win_valid;
    logic [2:0] win_idx;
    modport unit (input req, order, rr_en, advance,
                  output win_valid, win_idx);
    modport ctrl (output req, order, rr_en, advance,
                  input win_valid, win_idx);
endinterface
`default_nettype wire

// ==== rtl/vpic_prio_unit.sv ====
// Purpose: one six-input priority unit, slave or master
// Assumes: inputs 0..3 programmable or rotating, 4 and 5 fixed
// Notes:   winner is combinational; rotation updates on advance
`timescale 1ns/1ps
`default_nettype none
module vpic_prio_unit (
    // clock and reset
    input  wire logic core_clk,
    input  wire logic rst,
    // controller side
    vpic_rank_if.unit rk
);
    localparam int PROG_IN_TOP = vpic_pkg::PROG_IN - 1;

    logic [1:0] rot_reg;
    logic [1:0] rank_in;

    always_comb begin
        rk.win_valid = 1'b0;
        rk.win_idx   = 3'h0;
        rank_in      = 2'h0;
        // fixed inputs lowest, first fixed above second
        if (rk.req[5]) begin
            rk.win_valid = 1'b1;
            rk.win_idx   = 3'h5;
        end
        if (rk.req[4]) begin
            rk.win_valid = 1'b1;
            rk.win_idx   = 3'h4;
        end
        // programmable ones above both; rank 0 checked last, wins
        for (int r = PROG_IN_TOP; r >= 0; r--) begin
            if (rk.rr_en) begin
                rank_in = rot_reg + 2'(r);
            end else begin
                rank_in = rk.order[2*r +: 2];
            end
            if (rk.req[rank_in]) begin
                rk.win_valid = 1'b1;
                rk.win_idx   = {1'b0, rank_in};
            end
        end
    end

    // granted rotating input drops to last place
    always_ff @(posedge core_clk) begin
        if (rst) begin
            rot_reg <= vpic_pkg::ROT_RESET;
        end else if (rk.advance && rk.rr_en && rk.win_valid
                     && !rk.win_idx[2]) begin
            rot_reg <= rk.win_idx[1:0] + 2'h1;
        end
    end
endmodule
`default_nettype wire

// ==== rtl/vpic_top.sv ====
// Purpose: vectored priority interrupt controller, core facing
// Assumes: all request and control inputs synchronous to core_clk
// Notes:   requests are levels; a high level sets pending each cycle
//
// How it works
// - 26 controller inputs from 30 sources, each with pending, mask, mode
// - four external pins ORed to one input; two uart errors likewise
// - after arbitration raise either the fast or the normal core line
// - per-source line select picks fast or normal delivery
// - pending is read only; write 1 to a clear port clears it
// - masked source still sets pending but is never serviced
// - global mask keeps pending updates but forwards nothing
// - hardware ranking only for normal-line sources in vectored mode
// - four slave units of six and one master unit of six
// - in a slave, four programmable above two fixed, fixed first wins
// - slave programmable order is programmed or round-robin
// - master: four groups above rtc alarm then adc, the lowest of all
// - master group order programmed or round-robin; first fixed wins
// - fast-line sources always beat normal-line sources
// - across groups the master group rank decides
// - within a group the slave unit ranking decides
// - fixed mapping of the 26 sources to groups and slots
// - vectored mode answers exception fetches with a branch word
// - branch = base opcode + ((vector - fetch - 8) >> 2)
// - each source has its own vector, 0x20 to 0xC0, by group
`timescale 1ns/1ps
`default_nettype none
module vpic_top #(
    parameter int ADDR_W = 32
) (
    // clock and reset
    input  wire logic        core_clk,
    input  wire logic        rst,
    // group a sources
    input  wire logic [3:0]  ext_request,
    input  wire logic [3:0]  ored_external_inputs,
    input  wire logic        rtc_tick_request,
    // group b sources
    input  wire logic [1:0]  general_dma_request,
    input  wire logic [1:0]  bridge_dma_request,
    input  wire logic        watchdog_request,
    input  wire logic [1:0]  ored_uart_error,
    // group c sources
    input  wire logic [5:0]  timer_request,
    // group d sources
    input  wire logic [1:0]  uart_rx_request,
    input  wire logic        i2c_request,
    input  wire logic        serial_io_request,
    input  wire logic [1:0]  uart_tx_request,
    // master direct sources
    input  wire logic        rtc_alarm_request,
    input  wire logic        adc_eoc_request,
    // configuration
    input  wire logic [25:0] source_mask_register,
    input  wire logic        global_mask,
    input  wire logic [25:0] line_select_register,
    input  wire logic        vectored_mode,
    input  wire logic [31:0] slave_order,
    input  wire logic [3:0]  slave_rr_enable,
    input  wire logic [7:0]  master_order,
    input  wire logic        master_rr_enable,
    // pending clear strobes, write one to clear
    input  wire logic [25:0] normal_pending_clear,
    input  wire logic [25:0] fast_pending_clear,
    // status
    output logic      [25:0] normal_pending_status,
    output logic      [4:0]  normal_winner,
    output logic             normal_winner_valid,
    // core side
    input  wire logic             fetch_valid,
    input  wire logic [ADDR_W-1:0] fetch_addr,
    output logic             normal_request,
    output logic             fast_request,
    output logic             insn_valid,
    output logic      [31:0] insn_data
);
    if (ADDR_W < 8) begin : g_bad_addr_w
        $error("vpic_top: ADDR_W must be at least 8");
    end

    localparam int NS = vpic_pkg::SRC_NUM;

    logic [NS-1:0] src;
    logic [NS-1:0] pend_reg;
    logic [NS-1:0] pend_next;
    logic [NS-1:0] serviceable;
    logic [NS-1:0] elig_normal;
    logic [NS-1:0] elig_fast;

    // source assembly in group and slot order
    always_comb begin
        src = '0;
        src[3:0]   = ext_request;
        src[4]     = |ored_external_inputs;
        src[5]     = rtc_tick_request;
        src[7:6]   = general_dma_request;
        src[9:8]   = bridge_dma_request;
        src[10]    = watchdog_request;
        src[11]    = |ored_uart_error;
        src[17:12] = timer_request;
        src[19:18] = uart_rx_request;
        src[20]    = i2c_request;
        src[21]    = serial_io_request;
        src[23:22] = uart_tx_request;
        src[vpic_pkg::RTC_IDX] = rtc_alarm_request;
        src[vpic_pkg::ADC_IDX] = adc_eoc_request;
    end

    // pending: set wins over clear, masks do not block setting
    always_comb begin
        pend_next = pend_reg;
        pend_next = pend_next & ~(normal_pending_clear
                                  | fast_pending_clear);
        pend_next = pend_next | src;
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            pend_reg <= vpic_pkg::PENDING_RESET;
        end else begin
            pend_reg <= pend_next;
        end
    end

    // eligibility per line
    always_comb begin
        serviceable = pend_reg & ~source_mask_register;
        if (global_mask) begin
            serviceable = '0;
        end
        elig_normal = serviceable & ~line_select_register;
        elig_fast   = serviceable & line_select_register;
    end

    // priority units: four slaves and one master
    vpic_rank_if rk_slave [vpic_pkg::GROUP_NUM] ();
    vpic_rank_if rk_master ();

    logic [3:0] slave_valid;
    logic [2:0] slave_idx [vpic_pkg::GROUP_NUM];
    logic       advance_pulse;

    for (genvar g = 0; g < vpic_pkg::GROUP_NUM; g++) begin : g_slave
        assign rk_slave[g].req = elig_normal[g*6 +: 6];
        assign rk_slave[g].order   = slave_order[g*8 +: 8];
        assign rk_slave[g].rr_en   = slave_rr_enable[g];
        assign rk_slave[g].advance = advance_pulse
                                     && rk_master.win_idx == 3'(g);
        assign slave_valid[g] = rk_slave[g].win_valid;
        assign slave_idx[g]   = rk_slave[g].win_idx;
        vpic_prio_unit u_slave (
            .core_clk (core_clk),
            .rst      (rst),
            .rk       (rk_slave[g])
        );
    end

    assign rk_master.req = {elig_normal[vpic_pkg::ADC_IDX],
                            elig_normal[vpic_pkg::RTC_IDX],
                            slave_valid};
    assign rk_master.order   = master_order;
    assign rk_master.rr_en   = master_rr_enable;
    assign rk_master.advance = advance_pulse;

    vpic_prio_unit u_master (
        .core_clk (core_clk),
        .rst      (rst),
        .rk       (rk_master)
    );

    // combine master and slave outcome into one source number
    logic [4:0]  nwin;
    logic        nwin_valid;
    logic [31:0] nvec;
    logic [2:0]  mwin;
    logic [2:0]  swin;

    always_comb begin
        mwin       = rk_master.win_idx;
        nwin_valid = rk_master.win_valid;
        swin       = slave_idx[mwin[1:0]];
        nwin       = 5'h0;
        nvec       = vpic_pkg::VEC_FIRST;
        if (mwin == 3'h4) begin
            nwin = 5'(vpic_pkg::RTC_IDX);
            nvec = vpic_pkg::VEC_RTC;
        end else if (mwin == 3'h5) begin
            nwin = 5'(vpic_pkg::ADC_IDX);
            nvec = vpic_pkg::VEC_ADC;
        end else begin
            nwin = 5'(mwin[1:0] * 6 + swin);
            nvec = vpic_pkg::VEC_FIRST
                   + 32'(mwin[1:0]) * vpic_pkg::VEC_GROUP_STEP
                   + 32'(swin) * vpic_pkg::VEC_SLOT_STEP;
        end
    end

    // fast line: lowest source number wins, no hardware ranking
    logic [4:0]  fwin;
    logic        fwin_valid;
    logic [31:0] fvec;

    always_comb begin
        fwin       = 5'h0;
        fwin_valid = 1'b0;
        for (int i = NS - 1; i >= 0; i--) begin
            if (elig_fast[i]) begin
                fwin       = 5'(i);
                fwin_valid = 1'b1;
            end
        end
        if (fwin == 5'(vpic_pkg::RTC_IDX)) begin
            fvec = vpic_pkg::VEC_RTC;
        end else if (fwin == 5'(vpic_pkg::ADC_IDX)) begin
            fvec = vpic_pkg::VEC_ADC;
        end else begin
            fvec = vpic_pkg::VEC_FIRST
                   + 32'(fwin / 5'h6) * vpic_pkg::VEC_GROUP_STEP
                   + 32'(fwin % 5'h6) * vpic_pkg::VEC_SLOT_STEP;
        end
    end

    // exception vector fetch decode
    logic [31:0] fetch_word;
    logic        hit_normal;
    logic        hit_fast;
    logic [31:0] branch_word;

    always_comb begin
        fetch_word = 32'(fetch_addr);
        hit_normal = fetch_valid && vectored_mode && nwin_valid
                     && fetch_word == vpic_pkg::IRQ_FETCH;
        hit_fast   = fetch_valid && vectored_mode && fwin_valid
                     && fetch_word == vpic_pkg::FIQ_FETCH;
        if (hit_fast) begin
            branch_word = vpic_pkg::BRANCH_BASE
                + ((fvec - vpic_pkg::FIQ_FETCH
                    - vpic_pkg::PC_AHEAD) >> 2);
        end else begin
            branch_word = vpic_pkg::BRANCH_BASE
                + ((nvec - vpic_pkg::IRQ_FETCH
                    - vpic_pkg::PC_AHEAD) >> 2);
        end
    end

    // rotation moves only when a normal vector is really handed out
    assign advance_pulse = hit_normal;

    // core request lines
    always_ff @(posedge core_clk) begin
        if (rst) begin
            normal_request <= 1'b0;
            fast_request   <= 1'b0;
        end else begin
            normal_request <= |elig_normal;
            fast_request   <= |elig_fast;
        end
    end

    // instruction data answer, one cycle after the fetch
    always_ff @(posedge core_clk) begin
        if (rst) begin
            insn_valid <= 1'b0;
            insn_data  <= vpic_pkg::INSN_RESET;
        end else begin
            insn_valid <= hit_normal || hit_fast;
            if (hit_normal || hit_fast) begin
                insn_data <= branch_word;
            end
        end
    end

    // status mirrors
    always_ff @(posedge core_clk) begin
        if (rst) begin
            normal_pending_status <= vpic_pkg::PENDING_RESET;
            normal_winner         <= 5'h0;
            normal_winner_valid   <= 1'b0;
        end else begin
            normal_pending_status <= pend_next;
            normal_winner         <= nwin;
            normal_winner_valid   <= nwin_valid;
        end
    end
endmodule
`default_nettype wire

// ==== sim/vpic_top_asserts.sv ====
// Purpose: port-level checks of the interrupt controller
// Assumes: one clock, synchronous active-high reset
// Notes:   bound into every vpic_top
`timescale 1ns/1ps
`default_nettype none
module vpic_top_asserts #(
    parameter int ADDR_W = 32
) (
    // clock and reset
    input wire logic              core_clk,
    input wire logic              rst,
    // sources and configuration
    input wire logic [3:0]        ext_request,
    input wire logic [3:0]        ored_external_inputs,
    input wire logic [1:0]        ored_uart_error,
    input wire logic [25:0]       source_mask_register,
    input wire logic              global_mask,
    input wire logic [25:0]       line_select_register,
    input wire logic              vectored_mode,
    input wire logic [25:0]       normal_pending_clear,
    // status and core side
    input wire logic [25:0]       normal_pending_status,
    input wire logic [4:0]        normal_winner,
    input wire logic              normal_winner_valid,
    input wire logic              fetch_valid,
    input wire logic [ADDR_W-1:0] fetch_addr,
    input wire logic              normal_request,
    input wire logic              fast_request,
    input wire logic              insn_valid,
    input wire logic [31:0]       insn_data
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);
    logic [25:0] live;
    logic        live_n;
    logic        live_f;
    logic        irq_hit;
    assign live = normal_pending_status & ~source_mask_register;
    assign live_n = |(live & ~line_select_register);
    assign live_f = |(live & line_select_register);
    assign irq_hit = fetch_valid && vectored_mode && normal_winner_valid
                     && fetch_addr == vpic_pkg::IRQ_FETCH;

    pend_set_a: assert property (ext_request[0] |=>
        normal_pending_status[0]) else $error("pending 0 not set");
    or_ext_a: assert property (|ored_external_inputs |=>
        normal_pending_status[4]) else $error("ored external lost");
    or_uart_a: assert property (|ored_uart_error |=>
        normal_pending_status[11]) else $error("ored uart lost");
    clear_pend_a: assert property (normal_pending_clear[0] &&
        !ext_request[0] |=> !normal_pending_status[0])
        else $error("pending 0 not cleared");
    gmask_hold_a: assert property (global_mask && $past(global_mask)
        |-> !normal_request && !fast_request)
        else $error("request under global mask");
    normal_cause_a: assert property (normal_request |->
        $past(live_n) && !$past(global_mask))
        else $error("normal request without cause");
    fast_cause_a: assert property (fast_request |->
        $past(live_f) && !$past(global_mask))
        else $error("fast request without cause");
    normal_rise_a: assert property (live_n
        && !global_mask |=> normal_request)
        else $error("normal request missing");
    insn_cause_a: assert property (insn_valid |->
        $past(fetch_valid) && $past(vectored_mode))
        else $error("branch word without vector fetch");
    branch_ext0_a: assert property (irq_hit && normal_winner == 5'h00
        |=> insn_valid && insn_data == vpic_pkg::BRANCH_BASE)
        else $error("wrong branch word for source 0");
endmodule
bind vpic_top vpic_top_asserts #(.ADDR_W(ADDR_W)) chk (.core_clk, .rst,
    .ext_request, .ored_external_inputs, .ored_uart_error,
    .source_mask_register, .global_mask, .line_select_register,
    .vectored_mode, .normal_pending_clear, .normal_pending_status,
    .normal_winner, .normal_winner_valid, .fetch_valid, .fetch_addr,
    .normal_request, .fast_request, .insn_valid, .insn_data);
`default_nettype wire

// ==== sim/vpic_core_model.sv ====
// Purpose: core model taking requests and fetching exception vectors
// Assumes: one-cycle fetch strobe
// Notes:   address lines toggle while no fetch is made
`timescale 1ns/1ps
`default_nettype none
module vpic_core_model (
    input  wire logic        core_clk,
    input  wire logic        rst,
    input  wire logic        take_normal,
    input  wire logic        take_fast,
    input  wire logic        normal_disable,
    input  wire logic        fast_disable,
    input  wire logic        normal_request,
    input  wire logic        fast_request,
    input  wire logic        insn_valid,
    input  wire logic [31:0] insn_data,
    output logic             fetch_valid,
    output logic      [31:0] fetch_addr,
    output logic      [31:0] insn_seen
);
    logic take_f;
    logic take_n;
    assign take_f = take_fast && fast_request && !fast_disable;
    assign take_n = take_normal && normal_request
                    && !normal_disable;
    always @(posedge core_clk) begin
        if (rst) begin
            fetch_valid <= 1'b0;
            fetch_addr  <= 32'h0000_0000;
            insn_seen   <= 32'h0000_0000;
        end else begin
            if (take_f) begin
                fetch_valid <= 1'b1;
                fetch_addr  <= vpic_pkg::FIQ_FETCH;
            end else if (take_n) begin
                fetch_valid <= 1'b1;
                fetch_addr  <= vpic_pkg::IRQ_FETCH;
            end else begin
                fetch_valid <= 1'b0;
                fetch_addr  <= ~fetch_addr;
            end
            if (insn_valid)
                insn_seen <= insn_data;
        end
    end
endmodule
`default_nettype wire

// ==== sim/vpic_top_test.sv ====
// Purpose: self-checking bench of the interrupt controller
// Assumes: raw holds the 30 source lines in port order
// Notes:   expectations come from vector layout constants
`timescale 1ns/1ps
`default_nettype none
module vpic_top_test;
    logic        core_clk = 1'b0;
    logic        rst = 1'b1;
    logic [29:0] raw = '0;
    logic [25:0] mask = '0, lsel = '0, nclr = '0, fclr = '0, pend;
    logic [31:0] sorder = 32'hE4E4_E4E4, idata, fa, seen;
    logic [7:0]  morder = 8'hE4;
    logic [3:0]  srr = '0;
    logic        gmask = 0, tn = 0, tf = 0, nreq, freq, ival, fv, winv;
    logic [4:0]  win;
    logic        vmode = 1'b1, mrr = 1'b0;
    int          ival_count = 0;
    int          err_count = 0, checks_done = 0, cycles = 0;
    always #2.5 core_clk = ~core_clk;
    vpic_top uut (.core_clk, .rst, .ext_request(raw[3:0]),
        .ored_external_inputs(raw[7:4]), .rtc_tick_request(raw[8]),
        .general_dma_request(raw[10:9]), .bridge_dma_request(raw[12:11]),
        .watchdog_request(raw[13]), .ored_uart_error(raw[15:14]),
        .timer_request(raw[21:16]), .uart_rx_request(raw[23:22]),
        .i2c_request(raw[24]), .serial_io_request(raw[25]),
        .uart_tx_request(raw[27:26]), .rtc_alarm_request(raw[28]),
        .adc_eoc_request(raw[29]), .source_mask_register(mask),
        .global_mask(gmask), .line_select_register(lsel),
        .vectored_mode(vmode), .slave_order(sorder), .slave_rr_enable(srr),
        .master_order(morder), .master_rr_enable(mrr),
        .normal_pending_clear(nclr), .fast_pending_clear(fclr),
        .normal_pending_status(pend), .normal_winner(win),
        .normal_winner_valid(winv), .fetch_valid(fv), .fetch_addr(fa),
        .normal_request(nreq), .fast_request(freq), .insn_valid(ival),
        .insn_data(idata));
    vpic_core_model core (.core_clk, .rst, .take_normal(tn), .take_fast(tf),
        .normal_disable(1'b0), .fast_disable(1'b0), .normal_request(nreq),
        .fast_request(freq), .insn_valid(ival), .insn_data(idata),
        .fetch_valid(fv), .fetch_addr(fa), .insn_seen(seen));
    task automatic chk(input string n, input logic [31:0] e, g);
        checks_done++;
        if (g !== e) begin
            err_count++;
            $display("ERROR %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic see(input int n);
        repeat (n) @(posedge core_clk);
        @(negedge core_clk);
    endtask
    function automatic logic [31:0] br(input int s, input logic [31:0] f);
        logic [31:0] v;
        v = vpic_pkg::VEC_FIRST + vpic_pkg::VEC_GROUP_STEP * (s / 6)
            + vpic_pkg::VEC_SLOT_STEP * (s % 6);
        if (s == 24) v = vpic_pkg::VEC_RTC;
        if (s == 25) v = vpic_pkg::VEC_ADC;
        return vpic_pkg::BRANCH_BASE + ((v - f - vpic_pkg::PC_AHEAD) >> 2);
    endfunction
    task automatic clr(input bit f);
        @(posedge core_clk) raw <= '0;
        @(posedge core_clk) {nclr, fclr} <= f ? {26'h0, ~26'h0} : ~52'h0;
        @(posedge core_clk) {nclr, fclr} <= '0;
        see(2);
        chk("pending", 32'h0, pend);
    endtask
    task automatic fetch(input bit f);
        @(posedge core_clk) {tn, tf} <= {!f, f};
        @(posedge core_clk) {tn, tf} <= 2'b00;
        see(3);
    endtask
    task automatic win_of(input logic [29:0] r, input int s);
        @(posedge core_clk) raw <= r;
        see(3);
        chk("winner", s, win);
        fetch(0);
        chk("branch", br(s, vpic_pkg::IRQ_FETCH), seen);
        clr(0);
    endtask
    task automatic t_or;
        int b[6] = '{4, 5, 6, 7, 14, 15};
        foreach (b[i]) begin
            @(posedge core_clk) raw <= 30'h1 << b[i];
            see(2);
            chk("ored pending", 1, pend[b[i] < 8 ? 4 : 11]);
            clr(0);
        end
    endtask
    task automatic t_mask;
        @(posedge core_clk) {mask, raw} <= {26'h000_1000, 30'h0001_0000};
        see(3);
        chk("masked pending", 1, pend[12]);
        chk("masked request", 0, nreq);
        @(posedge core_clk) {mask, gmask} <= 27'h1;
        see(3);
        chk("global request", 0, nreq);
        chk("global pending", 1, pend[12]);
        @(posedge core_clk) gmask <= 1'b0;
        see(3);
        chk("open request", 1, nreq);
        clr(0);
    endtask
    task automatic t_fast;
        @(posedge core_clk) {lsel, raw} <= {26'h2, 30'h6};
        see(3);
        chk("fast request", 1, freq);
        fetch(1);
        chk("fast branch", br(1, vpic_pkg::FIQ_FETCH), seen);
        clr(1);
        @(posedge core_clk) lsel <= '0;
    endtask
    task automatic t_prio;
        win_of(30'h0000_0001, 0);
        win_of(30'h3000_0100, 5);
        win_of(30'h0000_0110, 4);
        win_of(30'h0000_0018, 3);
        win_of(30'h3000_0000, 24);
        win_of(30'h2000_0000, 25);
        @(posedge core_clk) morder <= 8'hD2;
        win_of(30'h0020_0001, 17);
        @(posedge core_clk) {morder, sorder[7:0]} <= 16'hE4D2;
        win_of(30'h0000_0005, 2);
    endtask
    task automatic t_rr;
        @(posedge core_clk) {srr, raw} <= {4'h4, 30'h000F_0000};
        see(3);
        for (int i = 0; i < 5; i++) begin
            chk("rotating winner", 12 + i % 4, win);
            fetch(0);
        end
        @(posedge core_clk) srr <= '0;
        clr(0);
    endtask
    task automatic t_mrr;
        @(posedge core_clk) {mrr, raw} <= {1'b1, 30'h0000_0201};
        see(3);
        for (int i = 0; i < 3; i++) begin
            chk("group rotation", i == 1 ? 6 : 0, win);
            fetch(0);
        end
        @(posedge core_clk) mrr <= 1'b0;
        clr(0);
    endtask
    task automatic t_nvec;
        int n0;
        n0 = ival_count;
        @(posedge core_clk) {vmode, raw} <= {1'b0, 30'h0000_0008};
        see(3);
        chk("plain request", 1, nreq);
        chk("plain pending", 1, pend[3]);
        fetch(0);
        chk("plain answers", n0, ival_count);
        @(posedge core_clk) vmode <= 1'b1;
        clr(0);
    endtask
    task automatic give_verdict;
        if (err_count == 0 && checks_done > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    always @(posedge core_clk) begin
        cycles <= cycles + 1;
        if (ival)
            ival_count <= ival_count + 1;
        if (cycles == 20000) begin
            err_count++;
            give_verdict();
        end
    end
    initial begin
        repeat (12) @(posedge core_clk);
        rst <= 1'b0;
        see(0);
        chk("reset pending", 32'h0, pend);
        chk("reset lines", 0, {nreq, freq, ival});
        t_or();
        t_mask();
        t_fast();
        t_prio();
        t_rr();
        t_mrr();
        t_nvec();
        give_verdict();
    end
endmodule
`default_nettype wire
